// File: hw/asp_map.svh
// register offsets, field positions and reset values of the serial audio port
//
// Behaviour
// - bits 7-6 pick TDM, I2S, left-justified; reset TDM
// - bits 5-4 pick 16/20/24/32-bit slots; reset 32
// - bits 3,2 invert frame-sync, bit-clock polarity
// - bit 1 delays data launch half cycle
// - bit 0: unused cycles drive zero or float
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH

// ----------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------
`define ASP_IDX_CFG_A    8'h07
`define ASP_IDX_CFG_B    8'h08
`define ASP_IDX_STATUS   8'h09

// ----------------------------------------
// reset values
// ----------------------------------------
`define ASP_RST_CFG_A    8'h30
`define ASP_RST_CFG_B    8'h00

// ----------------------------------------
// field positions in serial_port_config_a
// ----------------------------------------
`define ASP_FMT_HI       7
`define ASP_FMT_LO       6
`define ASP_WLEN_HI      5
`define ASP_WLEN_LO      4
`define ASP_FSPOL_BIT    3
`define ASP_BCPOL_BIT    2
`define ASP_EDGE_BIT     1
`define ASP_FILL_BIT     0

// ----------------------------------------
// field positions in the status register
// ----------------------------------------
`define ASP_ST_BUSY      0
`define ASP_ST_HELD      1
`define ASP_ST_RSVD      2
`define ASP_ST_FTOG      3
`define ASP_ST_FCNT_LO   8
`define ASP_ST_FCNT_HI   15

// ----------------------------------------
// bus answers
// ----------------------------------------
`define ASP_RESP_OKAY    2'h0
`define ASP_RESP_DECERR  2'h3

`endif

// File: hw/asp_pkg.sv
// types of the serial audio port
package asp_pkg;
  typedef enum logic [1:0] {
    ASP_TDM  = 2'h0,
    ASP_I2S  = 2'h1,
    ASP_LEFT = 2'h2,
    ASP_RSVD = 2'h3
  } asp_proto_t;

  typedef enum logic [1:0] {
    ASP_W16 = 2'h0,
    ASP_W20 = 2'h1,
    ASP_W24 = 2'h2,
    ASP_W32 = 2'h3
  } asp_wlen_t;
endpackage

// File: hw/asp_serial_port.sv
// serial audio port: config registers on axi4-lite, transmitter on the bit clock
//
// The AXI4-Lite register port is this design's own decision.
`include "asp_map.svh"

module asp_serial_port #(
  parameter int ADDR_W = 8
) (
  input  wire logic                clock,
  input  wire logic                rst,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output      logic                s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output      logic                s_axi_wready,
  output      logic [1:0]          s_axi_bresp,
  output      logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output      logic                s_axi_arready,
  output      logic [31:0]         s_axi_rdata,
  output      logic [1:0]          s_axi_rresp,
  output      logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // sample words from the core
  input  wire logic [31:0]         sampleA,
  input  wire logic [31:0]         sampleB,
  input  wire logic                sampleValid,
  output      logic                sampleReady,
  // serial link
  input  wire logic                bitClk,
  input  wire logic                frameSync,
  output      logic [1:0]          dataOut,
  output      logic [1:0]          dataOe
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (ADDR_W < 6 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must lie in 6..32");
  end

  localparam logic [ADDR_W-1:0] ADDR_CFG_A  = ADDR_W'({`ASP_IDX_CFG_A, 2'h0});
  localparam logic [ADDR_W-1:0] ADDR_CFG_B  = ADDR_W'({`ASP_IDX_CFG_B, 2'h0});
  localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'({`ASP_IDX_STATUS, 2'h0});

  // ----------------------------------------
  // axi write path
  // ----------------------------------------
  logic              awHeld_ff;
  logic              wHeld_ff;
  logic [ADDR_W-1:0] awAddr_ff;
  logic [7:0]        wData_ff;
  logic              wStrb_ff;
  logic              bValid_ff;
  logic [1:0]        bResp_ff;
  logic              doWrite;
  logic [7:0]        cfgA_ff;
  logic [7:0]        cfgB_ff;
  logic              cfgDirty_ff;

  assign s_axi_awready = ~awHeld_ff & ~bValid_ff;
  assign s_axi_wready  = ~wHeld_ff & ~bValid_ff;
  assign s_axi_bvalid  = bValid_ff;
  assign s_axi_bresp   = bResp_ff;
  assign doWrite       = awHeld_ff & wHeld_ff & ~bValid_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_ff <= 1'b1;
      awAddr_ff <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wHeld_ff <= 1'b0;
      wData_ff <= 8'h00;
      wStrb_ff <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_ff <= 1'b1;
      wData_ff <= s_axi_wdata[7:0];
      wStrb_ff <= s_axi_wstrb[0];
    end else if (doWrite) begin
      wHeld_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      bValid_ff <= 1'b0;
      bResp_ff  <= `ASP_RESP_OKAY;
    end else if (doWrite) begin
      bValid_ff <= 1'b1;
      if (awAddr_ff == ADDR_CFG_A || awAddr_ff == ADDR_CFG_B ||
          awAddr_ff == ADDR_STATUS) begin
        bResp_ff <= `ASP_RESP_OKAY;
      end else begin
        bResp_ff <= `ASP_RESP_DECERR;
      end
    end else if (s_axi_bready) begin
      bValid_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // config registers
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      cfgA_ff <= `ASP_RST_CFG_A;
      cfgB_ff <= `ASP_RST_CFG_B;
    end else if (doWrite && wStrb_ff) begin
      if (awAddr_ff == ADDR_CFG_A) begin
        cfgA_ff <= wData_ff;
      end
      if (awAddr_ff == ADDR_CFG_B) begin
        cfgB_ff <= wData_ff;
      end
    end
  end

  // ----------------------------------------
  // crossing to the bit clock: toggle request, toggle acknowledge
  // ----------------------------------------
  logic        sampleHeld_ff;
  logic [31:0] holdA_ff;
  logic [31:0] holdB_ff;
  logic        busy_ff;
  logic        reqTog_ff;
  logic [7:0]  snapCfg_ff;
  logic [31:0] snapA_ff;
  logic [31:0] snapB_ff;
  logic        ackS1_ff;
  logic        ackS2_ff;
  logic        launch;

  assign sampleReady = ~sampleHeld_ff;
  assign launch      = ~busy_ff & (cfgDirty_ff | sampleHeld_ff);

  always_ff @(posedge clock) begin
    if (rst) begin
      cfgDirty_ff <= 1'b1;
    end else if (doWrite && wStrb_ff && awAddr_ff == ADDR_CFG_A) begin
      cfgDirty_ff <= 1'b1;
    end else if (launch) begin
      cfgDirty_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sampleHeld_ff <= 1'b0;
      holdA_ff      <= 32'h0000_0000;
      holdB_ff      <= 32'h0000_0000;
    end else if (sampleValid && sampleReady) begin
      sampleHeld_ff <= 1'b1;
      holdA_ff      <= sampleA;
      holdB_ff      <= sampleB;
    end else if (launch) begin
      sampleHeld_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      busy_ff    <= 1'b0;
      reqTog_ff  <= 1'b0;
      snapCfg_ff <= `ASP_RST_CFG_A;
      snapA_ff   <= 32'h0000_0000;
      snapB_ff   <= 32'h0000_0000;
    end else if (launch) begin
      busy_ff    <= 1'b1;
      reqTog_ff  <= ~reqTog_ff;
      snapCfg_ff <= cfgA_ff;
      if (sampleHeld_ff) begin
        snapA_ff <= holdA_ff;
        snapB_ff <= holdB_ff;
      end
    end else if (busy_ff && ackS2_ff == reqTog_ff) begin
      busy_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // status from the link: frame toggle synchroniser and counter
  // ----------------------------------------
  logic       ackTog_ff;
  logic       frameTog_ff;
  logic       ftS1_ff;
  logic       ftS2_ff;
  logic       ftS3_ff;
  logic [7:0] frameCnt_ff;

  always_ff @(posedge clock) begin
    ackS1_ff <= ackTog_ff;
    ackS2_ff <= ackS1_ff;
    ftS1_ff  <= frameTog_ff;
    ftS2_ff  <= ftS1_ff;
    ftS3_ff  <= ftS2_ff;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      frameCnt_ff <= 8'h00;
    end else if (ftS2_ff != ftS3_ff) begin
      frameCnt_ff <= frameCnt_ff + 8'h01;
    end
  end

  // ----------------------------------------
  // axi read path
  // ----------------------------------------
  logic        rValid_ff;
  logic [31:0] rData_ff;
  logic [1:0]  rResp_ff;
  logic [31:0] statusWord;

  always_comb begin
    statusWord                                   = 32'h0000_0000;
    statusWord[`ASP_ST_BUSY]                     = busy_ff;
    statusWord[`ASP_ST_HELD]                     = sampleHeld_ff;
    statusWord[`ASP_ST_RSVD]                     =
      (cfgA_ff[`ASP_FMT_HI:`ASP_FMT_LO] == asp_pkg::ASP_RSVD);
    statusWord[`ASP_ST_FTOG]                     = ftS2_ff;
    statusWord[`ASP_ST_FCNT_HI:`ASP_ST_FCNT_LO]  = frameCnt_ff;
  end

  assign s_axi_arready = ~rValid_ff;
  assign s_axi_rvalid  = rValid_ff;
  assign s_axi_rdata   = rData_ff;
  assign s_axi_rresp   = rResp_ff;

  always_ff @(posedge clock) begin
    if (rst) begin
      rValid_ff <= 1'b0;
      rData_ff  <= 32'h0000_0000;
      rResp_ff  <= `ASP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_ff <= 1'b1;
      rResp_ff  <= `ASP_RESP_OKAY;
      if (s_axi_araddr == ADDR_CFG_A) begin
        rData_ff <= {24'h00_0000, cfgA_ff};
      end else if (s_axi_araddr == ADDR_CFG_B) begin
        rData_ff <= {24'h00_0000, cfgB_ff};
      end else if (s_axi_araddr == ADDR_STATUS) begin
        rData_ff <= statusWord;
      end else begin
        rData_ff <= 32'h0000_0000;
        rResp_ff <= `ASP_RESP_DECERR;
      end
    end else if (s_axi_rready) begin
      rValid_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // link domain: reset, request and pin synchronisers
  // ----------------------------------------
  logic        lrS1_ff;
  logic        lrst;
  logic        reqS1_ff;
  logic        reqS2_ff;
  logic        reqS3_ff;
  logic        fsP1_ff;
  logic        fsP2_ff;
  logic        fsN1_ff;
  logic        fsN2_ff;
  logic [7:0]  lCfg_ff;
  logic [31:0] lA_ff;
  logic [31:0] lB_ff;

  always_ff @(posedge bitClk) begin
    lrS1_ff  <= rst;
    lrst     <= lrS1_ff;
    reqS1_ff <= reqTog_ff;
    reqS2_ff <= reqS1_ff;
    reqS3_ff <= reqS2_ff;
    fsP1_ff  <= frameSync;
    fsP2_ff  <= fsP1_ff;
  end

  always_ff @(negedge bitClk) begin
    fsN1_ff <= frameSync;
    fsN2_ff <= fsN1_ff;
  end

  always_ff @(posedge bitClk) begin
    if (lrst) begin
      ackTog_ff <= 1'b0;
      lCfg_ff   <= `ASP_RST_CFG_A;
      lA_ff     <= 32'h0000_0000;
      lB_ff     <= 32'h0000_0000;
    end else if (reqS2_ff != reqS3_ff) begin
      ackTog_ff <= reqS2_ff;
      lCfg_ff   <= snapCfg_ff;
      lA_ff     <= snapA_ff;
      lB_ff     <= snapB_ff;
    end
  end

  // ----------------------------------------
  // link domain: frame tracking and bit selection
  // ----------------------------------------
  asp_pkg::asp_proto_t proto;
  logic [5:0]          wl;
  logic                fsLvl;
  logic                fsPrev_ff;
  logic                rise;
  logic                fall;
  logic                start;
  logic [6:0]          cnt_ff;
  logic [6:0]          curCnt;
  logic [6:0]          pos;
  logic [5:0]          idx;
  logic                chanB_ff;
  logic                nxtChanB;
  logic                slotB;
  logic                act;
  logic [31:0]         actA_ff;
  logic [31:0]         actB_ff;
  logic [31:0]         wordP;
  logic [31:0]         wordS;
  logic [1:0]          bits;

  assign proto = asp_pkg::asp_proto_t'(lCfg_ff[`ASP_FMT_HI:`ASP_FMT_LO]);

  always_comb begin
    unique case (asp_pkg::asp_wlen_t'(lCfg_ff[`ASP_WLEN_HI:`ASP_WLEN_LO]))
      asp_pkg::ASP_W16: wl = 6'd16;
      asp_pkg::ASP_W20: wl = 6'd20;
      asp_pkg::ASP_W24: wl = 6'd24;
      asp_pkg::ASP_W32: wl = 6'd32;
    endcase
  end

  // sampling edge follows bit-clock polarity, level follows frame-sync polarity
  assign fsLvl = (lCfg_ff[`ASP_BCPOL_BIT] ? fsN2_ff : fsP2_ff)
               ^ lCfg_ff[`ASP_FSPOL_BIT] ^ (proto == asp_pkg::ASP_I2S);
  assign rise  = fsLvl & ~fsPrev_ff;
  assign fall  = ~fsLvl & fsPrev_ff;
  assign start = rise | (fall & (proto != asp_pkg::ASP_TDM));

  always_comb begin
    curCnt   = start ? 7'd0 : cnt_ff;
    nxtChanB = rise ? 1'b0 : (fall ? 1'b1 : chanB_ff);
    pos      = curCnt - {6'd0, proto == asp_pkg::ASP_I2S};
    slotB    = 1'b0;
    idx      = pos[5:0];
    act      = 1'b0;
    if (proto == asp_pkg::ASP_I2S && curCnt == 7'd0) begin
      act = 1'b0;
    end else if (proto == asp_pkg::ASP_TDM) begin
      act   = pos < {wl, 1'b0};
      slotB = pos >= {1'b0, wl};
      idx   = slotB ? 6'(pos - {1'b0, wl}) : pos[5:0];
    end else if (proto != asp_pkg::ASP_RSVD) begin
      act   = pos < {1'b0, wl};
      slotB = nxtChanB;
    end
    wordP = slotB ? actB_ff : actA_ff;
    wordS = slotB ? actA_ff : actB_ff;
    bits  = 2'b00;
    if (act) begin
      bits = {wordS[5'(wl - 6'd1 - idx)], wordP[5'(wl - 6'd1 - idx)]};
    end
  end

  always_ff @(posedge bitClk) begin
    if (lrst) begin
      fsPrev_ff   <= 1'b0;
      cnt_ff      <= 7'h7f;
      chanB_ff    <= 1'b0;
      frameTog_ff <= 1'b0;
      actA_ff     <= 32'h0000_0000;
      actB_ff     <= 32'h0000_0000;
    end else begin
      fsPrev_ff <= fsLvl;
      chanB_ff  <= nxtChanB;
      if (curCnt != 7'h7f) begin
        cnt_ff <= curCnt + 7'd1;
      end else begin
        cnt_ff <= curCnt;
      end
      if (rise) begin
        frameTog_ff <= ~frameTog_ff;
        actA_ff     <= lA_ff;
        actB_ff     <= lB_ff;
      end
    end
  end

  // ----------------------------------------
  // link domain: launch edge selection and pin drive
  // ----------------------------------------
  logic [1:0] bitP_ff;
  logic       actP_ff;
  logic [1:0] bitN_ff;
  logic       actN_ff;
  logic [1:0] bitL_ff;
  logic       actL_ff;
  logic [1:0] outBits;
  logic       outAct;

  always_ff @(posedge bitClk) begin
    if (lrst) begin
      bitP_ff <= 2'b00;
      actP_ff <= 1'b0;
      bitL_ff <= 2'b00;
      actL_ff <= 1'b0;
    end else begin
      bitP_ff <= bits;
      actP_ff <= act;
      bitL_ff <= bitP_ff;
      actL_ff <= actP_ff;
    end
  end

  always_ff @(negedge bitClk) begin
    if (lrst) begin
      bitN_ff <= 2'b00;
      actN_ff <= 1'b0;
    end else begin
      bitN_ff <= bitP_ff;
      actN_ff <= actP_ff;
    end
  end

  always_comb begin
    unique case ({lCfg_ff[`ASP_BCPOL_BIT], lCfg_ff[`ASP_EDGE_BIT]})
      2'b00: begin
        outBits = bitN_ff;
        outAct  = actN_ff;
      end
      2'b01: begin
        outBits = bitL_ff;
        outAct  = actL_ff;
      end
      2'b10: begin
        outBits = bitP_ff;
        outAct  = actP_ff;
      end
      2'b11: begin
        outBits = bitN_ff;
        outAct  = actN_ff;
      end
    endcase
  end

  for (genvar p = 0; p < 2; p++) begin : g_pin
    assign dataOut[p] = outAct & outBits[p];
    assign dataOe[p]  = outAct | ~lCfg_ff[`ASP_FILL_BIT];
  end

endmodule

// File: verif/asp_host_model.sv
// host side of the serial link: bit clock, frame sync, data capture
module asp_host_model (
  input  wire logic        bcPol,
  input  wire logic        txEdge,
  input  wire logic [1:0]  dataOut,
  input  wire logic [1:0]  dataOe,
  output      logic        bitClk,
  output      logic        frameSync,
  output      logic [79:0] capP,
  output      logic [79:0] capS,
  output      logic [7:0]  hizCnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0]  bitCnt;
  logic [79:0] curP;
  logic [79:0] curS;
  logic [7:0]  hizAcc;
  wire         pinP = dataOe[0] ? dataOut[0] : 1'bz;
  wire         pinS = dataOe[1] ? dataOut[1] : 1'bz;
  initial begin
    bitClk = 1'b0;
    frameSync = 1'b0;
    bitCnt = 7'd0;
    hizAcc = 8'h00;
    #7;
    forever #15 bitClk = ~bitClk;
  end
  // 80-bit frame, sync high for the first half, launched off the edge opposite the sampling edge
  always @(bitClk) if (bitClk === bcPol) begin
    bitCnt <= (bitCnt == 7'd79) ? 7'd0 : bitCnt + 7'd1;
    frameSync <= (bitCnt == 7'd79) || (bitCnt < 7'd39);
  end
  // data read on the edge opposite its launch
  always @(bitClk) if (bitClk !== (bcPol ^ txEdge)) begin
    curP[bitCnt] <= pinP;
    curS[bitCnt] <= pinS;
    if (bitCnt == 7'd0) begin
      capP <= curP;
      capS <= curS;
      hizCnt <= hizAcc;
      hizAcc <= {7'd0, !dataOe[0]};
    end else begin
      hizAcc <= hizAcc + {7'd0, !dataOe[0]};
    end
  end
endmodule

// File: verif/asp_serial_port_asserts.sv
// checker of the register bus and sample handshakes
module asp_serial_port_asserts (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        sampleValid,
  input wire logic        sampleReady
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_ANSWER: assert property (wrTaken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  AST_B_BLOCKS: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  AST_RD_ANSWER: assert property (rdTaken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read dropped");
  AST_R_DECERR: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |->
    s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0000_0000) else $error("bad error answer");
  AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  AST_SMP_TAKE: assert property (sampleValid && sampleReady |=> !sampleReady)
    else $error("sample port still ready");
endmodule

bind asp_serial_port asp_serial_port_asserts u_asp_serial_port_asserts (
  .clock(clock), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sampleValid(sampleValid),
  .sampleReady(sampleReady)
);

// File: verif/asp_serial_port_test.sv
// testbench of the serial audio port
`include "asp_map.svh"
module asp_serial_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ADDR_A = 8'(`ASP_IDX_CFG_A * 4);
  localparam logic [7:0] ADDR_B = 8'(`ASP_IDX_CFG_B * 4);
  localparam logic [7:0] ADDR_S = 8'(`ASP_IDX_STATUS * 4);
  logic        clock, rst, bitClk, frameSync, bcPol, txEdge;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, hizCnt;
  logic [31:0] s_axi_wdata, s_axi_rdata, sampleA, sampleB, d;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, sampleValid, sampleReady;
  logic [1:0]  s_axi_bresp, s_axi_rresp, dataOut, dataOe, r;
  logic [79:0] capP, capS;
  logic [7:0]  cfgs [11];
  int          badCount, nChecks, wl, pA, pB, pS, dExp;

  asp_serial_port #(.ADDR_W(8)) u_asp_serial_port (.clock(clock), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sampleA(sampleA),
    .sampleB(sampleB), .sampleValid(sampleValid), .sampleReady(sampleReady),
    .bitClk(bitClk), .frameSync(frameSync), .dataOut(dataOut), .dataOe(dataOe));
  asp_host_model u_asp_host_model (.bcPol(bcPol), .txEdge(txEdge), .dataOut(dataOut),
    .dataOe(dataOe), .bitClk(bitClk), .frameSync(frameSync), .capP(capP), .capS(capS),
    .hizCnt(hizCnt));

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rsp);
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask
  task rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rsp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    dat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask
  function automatic int find(logic [79:0] cap, logic [31:0] w, int len);
    for (int o = 0; o + len <= 80; o++) begin
      bit ok;
      ok = 1'b1;
      for (int i = 0; i < len; i++) if (cap[o+i] !== w[len-1-i]) ok = 1'b0;
      if (ok) return o;
    end
    return -1;
  endfunction
  task giveVerdict;
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #200000;
    badCount++;
    $display("watchdog expired");
    giveVerdict;
  end
  initial begin
    rst = 1'b1; s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00; s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h1; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; sampleA = 32'hA5C3_96E1;
    sampleB = 32'h5A3C_E71B; sampleValid = 1'b0; bcPol = 1'b0; txEdge = 1'b0;
    badCount = 0; nChecks = 0;
    cfgs = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h81, 8'h41, 8'h89, 8'h85, 8'h83, 8'h80, 8'h87};
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(ADDR_A, d, r);
    check("config a reset", d, 32'h0000_0030);
    check("config a answer", {30'h0, r}, 32'h0000_0000);
    rd(ADDR_B, d, r);
    check("config b reset", d, 32'h0000_0000);
    wr(ADDR_B, 32'h0000_00A5, r);
    check("config b answer", {30'h0, r}, 32'h0000_0000);
    rd(ADDR_B, d, r);
    check("config b data", d, 32'h0000_00A5);
    s_axi_wstrb <= 4'h0;
    wr(ADDR_B, 32'h0000_005A, r);
    s_axi_wstrb <= 4'h1;
    check("masked write answer", {30'h0, r}, 32'h0000_0000);
    rd(ADDR_B, d, r);
    check("masked write data", d, 32'h0000_00A5);
    wr(8'h40, 32'h0000_0011, r);
    check("unmapped write", {30'h0, r}, 32'h0000_0003);
    rd(8'h40, d, r);
    check("unmapped read", {30'h0, r}, 32'h0000_0003);
    check("unmapped data", d, 32'h0000_0000);
    $display("test registers done");
    sampleValid <= 1'b1;
    do @(posedge clock); while (sampleReady !== 1'b1);
    sampleValid <= 1'b0;
    foreach (cfgs[k]) begin
      // protocol code three is never programmed
      wr(ADDR_A, {24'h0, cfgs[k]}, r);
      check("config a write answer", {30'h0, r}, 32'h0000_0000);
      bcPol <= cfgs[k][2];
      txEdge <= cfgs[k][1];
      repeat (1000) @(posedge clock);
      rd(ADDR_A, d, r);
      check("config a data", d, {24'h0, cfgs[k]});
      wl = (cfgs[k][5:4] == 2'd3) ? 32 : 16 + 4 * cfgs[k][5:4];
      pA = find(capP, sampleA, wl);
      pB = find(capP, sampleB, wl);
      pS = find(capS, sampleB, wl);
      dExp = (cfgs[k][7:6] == 2'd0) ? wl : (((cfgs[k][7:6] == 2'd1) ^ cfgs[k][3]) ? -40 : 40);
      check("word found", 32'(pA >= 0), 32'h0000_0001);
      check("slot spacing", 32'(pB - pA), 32'(dExp));
      check("secondary slot", 32'(pS), 32'(pA));
      check("unused cycles", {24'h0, hizCnt}, cfgs[k][0] ? 32'(80 - 2 * wl) : 0);
      $display("test link config %h done", cfgs[k]);
    end
    rd(ADDR_S, d, r);
    check("status answer", {30'h0, r}, 32'h0000_0000);
    check("status flags", {29'h0, d[2:0]}, 32'h0000_0000);
    check("status upper", {16'h0, d[31:16]}, 32'h0000_0000);
    $display("test status done");
    giveVerdict;
  end
endmodule
